// *** verilog/sbil_top.sv ***
// Speed limit select, torque feed-forward and brake interlock sequencer
//
// Summary of operation
// - Torque control caps speed at fixed limit
// - Fixed limit clamped by motor speed variant
// - Setup bit 2 selects analog speed limit
// - Analog limit is positive level times speed scale
// - Positive volts both directions, negative gives zero
// - Speed scale default 300, range 10..2000
// - Setup bit 9 makes torque input feed-forward
// - Speed control adds scaled feed-forward to loop
// - Torque scale in 0.1 V per rated, default 30
// - Feed-forward sign gives acceleration direction
// - First delay from brake command to power off
// - Brake speed threshold default 100 r/min
// - Second delay max from servo-off, 10..100
// - Brake output drops on threshold or timeout
// - Run command on enters servo-on, energises motor
// - Power-up initialises then enters status display
// - Analog current limit off when feed-forward on
//
// The placing of the registers and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
module sbil_top #(
   parameter int TICK_CYCLES = sbil_pkg::TICK_CYC,
   parameter int DATA_W      = 16
) (
   // Clock and reset
   input  wire logic              SYS_CLK,
   input  wire logic              NRST,
   // AHB-Lite slave
   input  wire logic              HSEL,
   input  wire logic [31:0]       HADDR,
   input  wire logic [1:0]        HTRANS,
   input  wire logic              HWRITE,
   input  wire logic [2:0]        HSIZE,
   input  wire logic [31:0]       HWDATA,
   input  wire logic              HREADY,
   output logic      [31:0]       HRDATA,
   output logic                   HREADYOUT,
   output logic                   HRESP,
   // Controller inputs, pins
   input  wire logic              RUN_CMD,
   input  wire logic signed [DATA_W-1:0] ANALOG_SPEED_MV,
   input  wire logic signed [DATA_W-1:0] ANALOG_TORQUE_MV,
   input  wire logic              CONTROL_TORQUE_MODE,
   // Motor feedback, same clock
   input  wire logic [DATA_W-1:0] MOTOR_SPEED,
   // Outputs to power stage and loops
   output logic                   MOTOR_POWER_ON,
   output logic                   BRAKE_INTERLOCK_OUT,
   output logic      [DATA_W-1:0] SPEED_LIMIT_OUT,
   output logic signed [31:0]     TORQUE_FF_OUT,
   output logic                   ANALOG_CUR_LIMIT_EN,
   output logic                   STATUS_DISPLAY
);
   // Pin synchronisers
   logic        run_s1, run_s2, tmode_s1, tmode_s2;
   logic signed [DATA_W-1:0] spd_s1, spd_s2, trq_s1, trq_s2;
   // Parameter registers
   logic [15:0] setup_switch_word, fixed_speed_limit, speed_command_scale;
   logic [15:0] torque_command_scale, brake_delay_first;
   logic [15:0] brake_speed_threshold, brake_delay_second;
   logic        motor_fast;
   // Bus address phase capture
   logic        dp_valid, dp_write;
   logic [7:0]  dp_addr;
   // Sequencer
   sbil_pkg::sbil_state_type state;
   logic [15:0] delay_cnt;
   logic [4:0]  init_cnt;
   logic        tick;
   // Derived values
   logic [15:0] spd_max, lim_fixed;
   logic [31:0] lim_analog, next_limit;
   logic signed [31:0] next_ff;

   // Two flip-flops on every pin input
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         run_s1   <= 1'b0;
         run_s2   <= 1'b0;
         tmode_s1 <= 1'b0;
         tmode_s2 <= 1'b0;
         spd_s1   <= '0;
         spd_s2   <= '0;
         trq_s1   <= '0;
         trq_s2   <= '0;
      end
      else
      begin
         run_s1   <= RUN_CMD;
         run_s2   <= run_s1;
         tmode_s1 <= CONTROL_TORQUE_MODE;
         tmode_s2 <= tmode_s1;
         spd_s1   <= ANALOG_SPEED_MV;
         spd_s2   <= spd_s1;
         trq_s1   <= ANALOG_TORQUE_MV;
         trq_s2   <= trq_s1;
      end
   end

   // 10 ms tick for the brake delays
   sbil_tick #(
      .PERIOD (TICK_CYCLES)
   ) u_tick (
      .SYS_CLK (SYS_CLK),
      .NRST    (NRST),
      .TICK    (tick)
   );

   // AHB-Lite address phase capture; slave is always zero wait
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= 8'h00;
      end
      else if (HREADY)
      begin
         dp_valid <= HSEL && HTRANS[1];
         dp_write <= HWRITE;
         dp_addr  <= HADDR[7:0];
      end
   end

   // Response is always OKAY with no wait states
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
      else
      begin
         HREADYOUT <= 1'b1;
         HRESP     <= 1'b0;
      end
   end

   // Parameter writes; scale and delay values are clamped on entry, the fixed limit only at use
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         setup_switch_word     <= sbil_pkg::RST_SETUP;
         fixed_speed_limit     <= sbil_pkg::RST_SPD_LIMIT;
         speed_command_scale   <= sbil_pkg::RST_SPD_SCALE;
         torque_command_scale  <= sbil_pkg::RST_TRQ_SCALE;
         brake_delay_first     <= sbil_pkg::RST_BRK_DELAY1;
         brake_speed_threshold <= sbil_pkg::RST_BRK_THRESH;
         brake_delay_second    <= sbil_pkg::RST_BRK_DELAY2;
         motor_fast            <= 1'b1;
      end
      else if (dp_valid && dp_write)
      begin
         case (dp_addr)
            sbil_pkg::OFS_SETUP:
               setup_switch_word <= HWDATA[15:0];
            sbil_pkg::OFS_SPD_LIMIT:
               fixed_speed_limit <= HWDATA[15:0];
            sbil_pkg::OFS_SPD_SCALE:
               speed_command_scale <=
                  (HWDATA[15:0] < sbil_pkg::MIN_SPD_SCALE) ?
                  sbil_pkg::MIN_SPD_SCALE :
                  (HWDATA[15:0] > sbil_pkg::MAX_SPD_SCALE) ?
                  sbil_pkg::MAX_SPD_SCALE : HWDATA[15:0];
            sbil_pkg::OFS_TRQ_SCALE:
               torque_command_scale <=
                  (HWDATA[15:0] < sbil_pkg::MIN_TRQ_SCALE) ?
                  sbil_pkg::MIN_TRQ_SCALE :
                  (HWDATA[15:0] > sbil_pkg::MAX_TRQ_SCALE) ?
                  sbil_pkg::MAX_TRQ_SCALE : HWDATA[15:0];
            sbil_pkg::OFS_BRK_DELAY1:
               brake_delay_first <=
                  (HWDATA[15:0] > sbil_pkg::MAX_BRK_DELAY1) ?
                  sbil_pkg::MAX_BRK_DELAY1 : HWDATA[15:0];
            sbil_pkg::OFS_BRK_THRESH:
               brake_speed_threshold <= HWDATA[15:0];
            sbil_pkg::OFS_BRK_DELAY2:
               brake_delay_second <=
                  (HWDATA[15:0] < sbil_pkg::MIN_BRK_DELAY2) ?
                  sbil_pkg::MIN_BRK_DELAY2 :
                  (HWDATA[15:0] > sbil_pkg::MAX_BRK_DELAY2) ?
                  sbil_pkg::MAX_BRK_DELAY2 : HWDATA[15:0];
            sbil_pkg::OFS_MOTOR_TYPE:
               motor_fast <= HWDATA[0];
            default: ;
         endcase
      end
   end

   // Read data, registered at the address phase so it meets the data phase
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
         HRDATA <= 32'h0000_0000;
      else if (HREADY && HSEL && HTRANS[1] && !HWRITE)
      begin
         case (HADDR[7:0])
            sbil_pkg::OFS_SETUP:      HRDATA <= {16'h0000, setup_switch_word};
            sbil_pkg::OFS_SPD_LIMIT:  HRDATA <= {16'h0000, fixed_speed_limit};
            sbil_pkg::OFS_SPD_SCALE:
               HRDATA <= {16'h0000, speed_command_scale};
            sbil_pkg::OFS_TRQ_SCALE:
               HRDATA <= {16'h0000, torque_command_scale};
            sbil_pkg::OFS_BRK_DELAY1: HRDATA <= {16'h0000, brake_delay_first};
            sbil_pkg::OFS_BRK_THRESH:
               HRDATA <= {16'h0000, brake_speed_threshold};
            sbil_pkg::OFS_BRK_DELAY2:
               HRDATA <= {16'h0000, brake_delay_second};
            sbil_pkg::OFS_MOTOR_TYPE: HRDATA <= {31'h0, motor_fast};
            sbil_pkg::OFS_STATUS:
               HRDATA <= {26'h0, ANALOG_CUR_LIMIT_EN, state,
                          MOTOR_POWER_ON, BRAKE_INTERLOCK_OUT};
            sbil_pkg::OFS_SPD_LIM_OUT:
               HRDATA <= {{(32-DATA_W){1'b0}}, SPEED_LIMIT_OUT};
            sbil_pkg::OFS_FF_OUT:     HRDATA <= TORQUE_FF_OUT;
            default:                  HRDATA <= 32'h0000_0000;
         endcase
      end
   end

   // Speed limit selection; a negative analog level means zero
   always_comb
   begin
      spd_max = motor_fast ? sbil_pkg::MAX_SPD_LIMIT_FAST
                           : sbil_pkg::MAX_SPD_LIMIT_SLOW;
      lim_fixed = (fixed_speed_limit > spd_max) ?
                  spd_max : fixed_speed_limit;
      // Millivolts times scale, divided back to r/min
      lim_analog = spd_s2[DATA_W-1] ? 32'h0000_0000 :
                   (32'(spd_s2) * 32'(speed_command_scale)) / 32'd1000;
      if (setup_switch_word[sbil_pkg::SETUP_ANALOG_SPD_BIT])
         next_limit = lim_analog;
      else
         next_limit = {16'h0000, lim_fixed};
      // Feed-forward: rated fraction scaled by 10000, sign kept
      if (setup_switch_word[sbil_pkg::SETUP_TRQ_FF_BIT] && !tmode_s2)
         next_ff = (32'(trq_s2) * 32'sd100) /
                   $signed({16'h0000, torque_command_scale});
      else
         next_ff = 32'sd0;
   end

   // Registered loop outputs; limit saturates at the output width
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         SPEED_LIMIT_OUT     <= '0;
         TORQUE_FF_OUT       <= 32'sd0;
         ANALOG_CUR_LIMIT_EN <= 1'b0;
      end
      else
      begin
         SPEED_LIMIT_OUT <= (next_limit > 32'((1 << DATA_W) - 1)) ?
                            '1 : next_limit[DATA_W-1:0];
         TORQUE_FF_OUT   <= next_ff;
         ANALOG_CUR_LIMIT_EN <=
            setup_switch_word[sbil_pkg::SETUP_ANALOG_CUR_BIT] &&
            !setup_switch_word[sbil_pkg::SETUP_TRQ_FF_BIT];
      end
   end

   // Power-up, run and stopping sequence for power and brake
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         state               <= sbil_pkg::ST_INIT;
         init_cnt            <= 5'h00;
         delay_cnt           <= 16'h0000;
         MOTOR_POWER_ON      <= 1'b0;
         BRAKE_INTERLOCK_OUT <= 1'b0;
         STATUS_DISPLAY      <= 1'b0;
      end
      else
      begin
         case (state)
            sbil_pkg::ST_INIT:
            begin
               init_cnt <= init_cnt + 5'h01;
               if (init_cnt == 5'(sbil_pkg::INIT_CYC - 1))
               begin
                  state          <= sbil_pkg::ST_DISPLAY;
                  STATUS_DISPLAY <= 1'b1;
               end
            end
            sbil_pkg::ST_DISPLAY:
               if (run_s2)
               begin
                  state               <= sbil_pkg::ST_SERVO_ON;
                  MOTOR_POWER_ON      <= 1'b1;
                  BRAKE_INTERLOCK_OUT <= 1'b1;
               end
            sbil_pkg::ST_SERVO_ON:
               if (!run_s2)
               begin
                  delay_cnt <= 16'h0000;
                  if (MOTOR_SPEED < brake_speed_threshold)
                  begin
                     // Stopped: brake first, power off after delay one
                     BRAKE_INTERLOCK_OUT <= 1'b0;
                     if (brake_delay_first == 16'h0000)
                     begin
                        MOTOR_POWER_ON <= 1'b0;
                        state          <= sbil_pkg::ST_DISPLAY;
                     end
                     else
                        state <= sbil_pkg::ST_BRAKE_WAIT;
                  end
                  else
                  begin
                     // Moving: power off now, brake held off
                     MOTOR_POWER_ON <= 1'b0;
                     state          <= sbil_pkg::ST_COAST;
                  end
               end
            sbil_pkg::ST_BRAKE_WAIT:
               if (tick)
               begin
                  delay_cnt <= delay_cnt + 16'h0001;
                  if (delay_cnt + 16'h0001 >= brake_delay_first)
                  begin
                     MOTOR_POWER_ON <= 1'b0;
                     state          <= sbil_pkg::ST_DISPLAY;
                  end
               end
            sbil_pkg::ST_COAST:
            begin
               if (tick)
                  delay_cnt <= delay_cnt + 16'h0001;
               if (MOTOR_SPEED < brake_speed_threshold ||
                   (tick && delay_cnt + 16'h0001 >= brake_delay_second))
               begin
                  BRAKE_INTERLOCK_OUT <= 1'b0;
                  state               <= sbil_pkg::ST_DISPLAY;
               end
            end
            default:
               state <= sbil_pkg::ST_INIT;
         endcase
      end
   end
endmodule

// *** verilog/sbil_pkg.sv ***
// Shared constants for the brake interlock and limit block
package sbil_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_SETUP        = 8'h00;
   localparam logic [7:0] OFS_SPD_LIMIT    = 8'h04;
   localparam logic [7:0] OFS_SPD_SCALE    = 8'h08;
   localparam logic [7:0] OFS_TRQ_SCALE    = 8'h0c;
   localparam logic [7:0] OFS_BRK_DELAY1   = 8'h10;
   localparam logic [7:0] OFS_BRK_THRESH   = 8'h14;
   localparam logic [7:0] OFS_BRK_DELAY2   = 8'h18;
   localparam logic [7:0] OFS_MOTOR_TYPE   = 8'h1c;
   localparam logic [7:0] OFS_STATUS       = 8'h20;
   localparam logic [7:0] OFS_SPD_LIM_OUT  = 8'h24;
   localparam logic [7:0] OFS_FF_OUT       = 8'h28;
   // Setup word bit positions
   localparam int SETUP_ANALOG_SPD_BIT = 2;
   localparam int SETUP_ANALOG_CUR_BIT = 8;
   localparam int SETUP_TRQ_FF_BIT     = 9;
   // Reset values
   localparam logic [15:0] RST_SETUP       = 16'h0000;
   localparam logic [15:0] RST_SPD_LIMIT   = 16'h05dc; // 1500 r/min
   localparam logic [15:0] RST_SPD_SCALE   = 16'h012c; // 300
   localparam logic [15:0] RST_TRQ_SCALE   = 16'h001e; // 30
   localparam logic [15:0] RST_BRK_DELAY1  = 16'h0000; // 0 x 10 ms
   localparam logic [15:0] RST_BRK_THRESH  = 16'h0064; // 100 r/min
   localparam logic [15:0] RST_BRK_DELAY2  = 16'h0032; // 50 x 10 ms
   // Parameter ranges
   localparam logic [15:0] MAX_SPD_LIMIT_SLOW = 16'h0bb8; // 3000
   localparam logic [15:0] MAX_SPD_LIMIT_FAST = 16'h1194; // 4500
   localparam logic [15:0] MIN_SPD_SCALE      = 16'h000a; // 10
   localparam logic [15:0] MAX_SPD_SCALE      = 16'h07d0; // 2000
   localparam logic [15:0] MIN_TRQ_SCALE      = 16'h000a; // 10
   localparam logic [15:0] MAX_TRQ_SCALE      = 16'h0064; // 100
   localparam logic [15:0] MAX_BRK_DELAY1     = 16'h0032; // 50
   localparam logic [15:0] MIN_BRK_DELAY2     = 16'h000a; // 10
   localparam logic [15:0] MAX_BRK_DELAY2     = 16'h0064; // 100
   // Timing
   localparam int CLK_HZ    = 100_000_000;
   localparam int TICK_MS   = 10;
   localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
   localparam int INIT_CYC  = 16;
   // Interlock sequence states
   typedef enum logic [2:0] {
      ST_INIT, ST_DISPLAY, ST_SERVO_ON, ST_BRAKE_WAIT, ST_COAST
   } sbil_state_type;
endpackage

// *** verilog/sbil_tick.sv ***
// Free running tick generator for the brake delay counters
`timescale 1ns/10ps
module sbil_tick #(
   parameter int PERIOD = 1_000_000
) (
   // Clock and reset
   input  wire logic SYS_CLK,
   input  wire logic NRST,
   // Tick out
   output logic      TICK
);
   logic [31:0] cnt;

   // Count one period, pulse for one cycle on wrap
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
      begin
         cnt  <= 32'h0000_0000;
         TICK <= 1'b0;
      end
      else if (cnt == 32'(PERIOD - 1))
      begin
         cnt  <= 32'h0000_0000;
         TICK <= 1'b1;
      end
      else
      begin
         cnt  <= cnt + 32'h0000_0001;
         TICK <= 1'b0;
      end
   end
endmodule

// *** testbench/sbil_properties.sv ***
// Concurrent property checker for the brake interlock and limit block
`timescale 1ns/10ps
module sbil_properties #(
   parameter int TICK_CYCLES = 20,
   parameter int DATA_W      = 16
) (
   // Clock and reset
   input wire logic                SYS_CLK,
   input wire logic                NRST,
   // Bus answer
   input wire logic                HREADYOUT,
   input wire logic                HRESP,
   // Controller pins
   input wire logic                RUN_CMD,
   input wire logic                CONTROL_TORQUE_MODE,
   // Drive outputs
   input wire logic                MOTOR_POWER_ON,
   input wire logic                BRAKE_INTERLOCK_OUT,
   input wire logic [DATA_W-1:0]   SPEED_LIMIT_OUT,
   input wire logic signed [31:0]  TORQUE_FF_OUT,
   input wire logic                STATUS_DISPLAY
);
   logic [4:0]  since_rst;
   logic [31:0] coast_cyc, hold_cyc;

   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   // Cycles since reset release, saturating so it never wraps
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
         since_rst <= 5'h00;
      else if (since_rst != 5'h1f)
         since_rst <= since_rst + 5'h01;
   end

   // Length of the coast with power off and brake still lifted
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
         coast_cyc <= 32'h0;
      else if (BRAKE_INTERLOCK_OUT && !MOTOR_POWER_ON)
         coast_cyc <= coast_cyc + 32'h1;
      else
         coast_cyc <= 32'h0;
   end

   // Length of the hold with brake applied and power still on
   always_ff @(posedge SYS_CLK or negedge NRST)
   begin
      if (!NRST)
         hold_cyc <= 32'h0;
      else if (MOTOR_POWER_ON && !BRAKE_INTERLOCK_OUT)
         hold_cyc <= hold_cyc + 32'h1;
      else
         hold_cyc <= 32'h0;
   end

   // Run request seen from the idle display state
   sequence s_run_rise;
      $rose(RUN_CMD) && STATUS_DISPLAY && !MOTOR_POWER_ON
         && !BRAKE_INTERLOCK_OUT;
   endsequence

   sequence s_energised;
      MOTOR_POWER_ON && BRAKE_INTERLOCK_OUT;
   endsequence

   chk_run_energise: assert property (
      s_run_rise ##1 RUN_CMD [*2] |-> ##1 s_energised)
      else $error("power and brake did not follow run");
   chk_stop_order: assert property (
      $fell(RUN_CMD) ##0 s_energised ##1 !RUN_CMD [*2]
         |-> s_energised ##1 !(MOTOR_POWER_ON && BRAKE_INTERLOCK_OUT))
      else $error("stop sequence late");
   chk_brake_with_power: assert property (
      $rose(BRAKE_INTERLOCK_OUT) |-> MOTOR_POWER_ON)
      else $error("brake lifted without motor power");
   chk_coast_bound: assert property (
      coast_cyc <= 32'(100 * TICK_CYCLES + 4))
      else $error("coast past second delay");
   chk_hold_bound: assert property (
      hold_cyc <= 32'(50 * TICK_CYCLES + 4))
      else $error("power stayed on past first delay");
   chk_init_dark: assert property (
      since_rst <= 5'h0d |-> !STATUS_DISPLAY && !MOTOR_POWER_ON)
      else $error("output before init done");
   chk_init_done: assert property (
      since_rst >= 5'h13 |-> STATUS_DISPLAY)
      else $error("no display after init");
   chk_reset_limit: assert property (
      since_rst == 5'h01 |-> SPEED_LIMIT_OUT == 16'h05dc)
      else $error("limit not default after reset");
   chk_ff_torque_mode: assert property (
      CONTROL_TORQUE_MODE [*5] |-> TORQUE_FF_OUT == 32'sh0)
      else $error("feed-forward in torque control");
   chk_bus_okay: assert property (
      HREADYOUT && !HRESP)
      else $error("bus answer not OKAY");
endmodule

// *** testbench/sbil_ctrl_model.sv ***
// Motion controller model driving run and analog pins
`timescale 1ns/10ps
module sbil_ctrl_model #(
   parameter int RELEASE_WAIT = 8
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               nrst,
   // Requests from the bench
   input  wire logic               want_run,
   input  wire logic               want_tmode,
   input  wire logic               accel,
   input  wire logic signed [15:0] want_spd,
   input  wire logic signed [15:0] want_trq,
   // Feedback from the drive
   input  wire logic               brake_lifted,
   // Pins into the drive
   output logic                    run_cmd,
   output logic                    tmode,
   output logic signed [15:0]      spd_mv,
   output logic signed [15:0]      trq_mv
);
   logic [7:0] lift_cnt;

   // Time since the brake lifted; it needs a while to clear
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         lift_cnt <= 8'h00;
      else if (!brake_lifted)
         lift_cnt <= 8'h00;
      else if (lift_cnt != 8'(RELEASE_WAIT))
         lift_cnt <= lift_cnt + 8'h01;
   end

   // Pins change only just after an edge
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         run_cmd <= 1'b0;
         tmode   <= 1'b0;
         spd_mv  <= 16'sh0000;
         trq_mv  <= 16'sh0000;
      end
      else
      begin
         run_cmd <= want_run;
         tmode   <= want_tmode;
         // Speed held at zero while a running brake is still clearing
         spd_mv  <= (want_run && lift_cnt != 8'(RELEASE_WAIT))
                    ? 16'sh0000 : want_spd;
         trq_mv  <= accel ? want_trq : 16'sh0000;
      end
   end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the brake interlock and limit block
`timescale 1ns/10ps
module tb;
   localparam int TICK = 20;
   logic               sys_clk = 1'b0;
   logic               nrst = 1'b0;
   logic               hsel = 1'b0, hwrite = 1'b0;
   logic [31:0]        haddr = 32'h0, hwdata = 32'h0;
   logic [1:0]         htrans = 2'h0;
   logic [31:0]        hrdata, rd;
   logic               want_run = 1'b0, want_tmode = 1'b0, accel = 1'b0;
   logic signed [15:0] want_spd = 16'sh0, want_trq = 16'sh0;
   logic signed [15:0] spd_mv, trq_mv;
   logic               hreadyout, run, tmode, power, brake, cur_en;
   logic [15:0]        limit, motor_speed = 16'h0;
   logic signed [31:0] ff;
   int                 bad_count = 0, checked = 0, cycles = 0;

   sbil_top #(.TICK_CYCLES(TICK)) sbil_top_inst (
      .SYS_CLK(sys_clk), .NRST(nrst), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(), .RUN_CMD(run), .ANALOG_SPEED_MV(spd_mv),
      .ANALOG_TORQUE_MV(trq_mv), .CONTROL_TORQUE_MODE(tmode),
      .MOTOR_SPEED(motor_speed), .MOTOR_POWER_ON(power),
      .BRAKE_INTERLOCK_OUT(brake), .SPEED_LIMIT_OUT(limit),
      .TORQUE_FF_OUT(ff), .ANALOG_CUR_LIMIT_EN(cur_en),
      .STATUS_DISPLAY());

   sbil_ctrl_model sbil_ctrl_model_inst (
      .sys_clk(sys_clk), .nrst(nrst), .want_run(want_run),
      .want_tmode(want_tmode), .accel(accel), .want_spd(want_spd),
      .want_trq(want_trq), .brake_lifted(brake), .run_cmd(run),
      .tmode(tmode), .spd_mv(spd_mv), .trq_mv(trq_mv));

   // Free running clock, 10 ns period
   initial
   begin
      forever #5 sys_clk = ~sys_clk;
   end

   // A hang ends the run as a mismatch
   always @(posedge sys_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 5000)
      begin
         bad_count++;
         conclude();
      end
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, exp);
      checked++;
      if (got !== exp)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One single transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {24'h0, a};
      hwrite <= w;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge sys_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      ahb(1'b0, a, 32'h0);
      cmp(rd, e);
   endtask

   task automatic wrchk(input logic [7:0] a, input logic [31:0] d, e);
      ahb(1'b1, a, d);
      rdchk(a, e);
   endtask

   // Outputs settle a few edges after their inputs move
   task automatic outs(input logic [31:0] l, f, input logic c);
      int n = 0;
      while (({16'h0, limit} !== l || ff !== f || cur_en !== c) && n < 12)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      cmp({16'h0, limit}, l);
      cmp(ff, f);
      cmp({31'h0, cur_en}, {31'h0, c});
   endtask

   // Wait for a power and brake pair, then check how long it took
   task automatic pb(input logic p, b, input int lim, lo);
      int n = 0;
      while ({power, brake} !== {p, b} && n < lim)
      begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      cmp({30'h0, power, brake}, {30'h0, p, b});
      cmp(32'(n >= lo), 32'h1);
   endtask

   initial
   begin
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      // Values after reset
      wrchk(sbil_pkg::OFS_SETUP, 32'h0, 32'h0);
      rdchk(sbil_pkg::OFS_SPD_SCALE, 32'h012c);
      rdchk(sbil_pkg::OFS_TRQ_SCALE, 32'h001e);
      rdchk(sbil_pkg::OFS_BRK_DELAY1, 32'h0);
      rdchk(sbil_pkg::OFS_BRK_THRESH, 32'h0064);
      rdchk(sbil_pkg::OFS_BRK_DELAY2, 32'h0032);
      want_tmode <= 1'b1;
      outs(32'h05dc, 32'h0, 1'b0);
      rdchk(sbil_pkg::OFS_STATUS, 32'h4);
      // Range limits applied on write, unmapped place reads zero
      wrchk(sbil_pkg::OFS_SPD_SCALE, 32'h5, 32'h000a);
      wrchk(sbil_pkg::OFS_SPD_SCALE, 32'h0bb8, 32'h07d0);
      wrchk(sbil_pkg::OFS_TRQ_SCALE, 32'h00c8, 32'h0064);
      wrchk(sbil_pkg::OFS_BRK_DELAY1, 32'h003c, 32'h0032);
      wrchk(sbil_pkg::OFS_BRK_DELAY2, 32'h5, 32'h000a);
      wrchk(sbil_pkg::OFS_BRK_DELAY2, 32'h00c8, 32'h0064);
      wrchk(sbil_pkg::OFS_BRK_THRESH, 32'h00fa, 32'h00fa);
      wrchk(8'h30, 32'h1234, 32'h0);
      wrchk(sbil_pkg::OFS_SPD_LIMIT, 32'h1388, 32'h1388);
      // Fixed limit capped by motor variant
      outs(32'h1194, 32'h0, 1'b0);
      wrchk(sbil_pkg::OFS_MOTOR_TYPE, 32'h0, 32'h0);
      outs(32'h0bb8, 32'h0, 1'b0);
      ahb(1'b1, sbil_pkg::OFS_MOTOR_TYPE, 32'h1);
      ahb(1'b1, sbil_pkg::OFS_SPD_LIMIT, 32'h0fa0);
      outs(32'h0fa0, 32'h0, 1'b0);
      // Limit taken from the analog speed reference
      ahb(1'b1, sbil_pkg::OFS_SETUP, 32'h4);
      want_spd <= 16'sh2710;
      outs(32'h4e20, 32'h0, 1'b0);
      ahb(1'b1, sbil_pkg::OFS_SPD_SCALE, 32'h012c);
      want_spd <= 16'sh07d0;
      outs(32'h0258, 32'h0, 1'b0);
      want_spd <= -16'sh07d0;
      outs(32'h0, 32'h0, 1'b0);
      // Torque reference used as feed-forward in speed control
      want_tmode <= 1'b0;
      accel <= 1'b1;
      want_trq <= 16'sh0bb8;
      ahb(1'b1, sbil_pkg::OFS_SETUP, 32'h0200);
      ahb(1'b1, sbil_pkg::OFS_TRQ_SCALE, 32'h001e);
      outs(32'h0fa0, 32'h2710, 1'b0);
      want_trq <= -16'sh05dc;
      outs(32'h0fa0, 32'hffffec78, 1'b0);
      want_tmode <= 1'b1;
      outs(32'h0fa0, 32'h0, 1'b0);
      want_tmode <= 1'b0;
      ahb(1'b1, sbil_pkg::OFS_SETUP, 32'h0100);
      outs(32'h0fa0, 32'h0, 1'b1);
      ahb(1'b1, sbil_pkg::OFS_SETUP, 32'h0300);
      outs(32'h0fa0, 32'hffffec78, 1'b0);
      // Brake sequencing with a stopped motor
      accel <= 1'b0;
      ahb(1'b1, sbil_pkg::OFS_SETUP, 32'h0);
      ahb(1'b1, sbil_pkg::OFS_BRK_DELAY1, 32'h2);
      ahb(1'b1, sbil_pkg::OFS_BRK_DELAY2, 32'h000a);
      want_run <= 1'b1;
      pb(1'b1, 1'b1, 12, 3);
      want_run <= 1'b0;
      pb(1'b1, 1'b0, 12, 3);
      pb(1'b0, 1'b0, 3 * TICK, TICK - 5);
      // Spinning motor that slows below the threshold
      motor_speed <= 16'h01f4;
      want_run <= 1'b1;
      pb(1'b1, 1'b1, 12, 3);
      want_run <= 1'b0;
      pb(1'b0, 1'b1, 12, 3);
      motor_speed <= 16'h0032;
      pb(1'b0, 1'b0, 4, 0);
      // Spinning motor that never slows: second delay ends the wait
      motor_speed <= 16'h01f4;
      want_run <= 1'b1;
      pb(1'b1, 1'b1, 12, 3);
      want_run <= 1'b0;
      pb(1'b0, 1'b1, 12, 3);
      pb(1'b0, 1'b0, 11 * TICK, 8 * TICK);
      conclude();
   end
endmodule

bind sbil_top sbil_properties #(.TICK_CYCLES(TICK_CYCLES), .DATA_W(DATA_W))
   sbil_properties_inst (
   .SYS_CLK(SYS_CLK), .NRST(NRST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
   .RUN_CMD(RUN_CMD), .CONTROL_TORQUE_MODE(CONTROL_TORQUE_MODE),
   .MOTOR_POWER_ON(MOTOR_POWER_ON),
   .BRAKE_INTERLOCK_OUT(BRAKE_INTERLOCK_OUT),
   .SPEED_LIMIT_OUT(SPEED_LIMIT_OUT), .TORQUE_FF_OUT(TORQUE_FF_OUT),
   .STATUS_DISPLAY(STATUS_DISPLAY));
